// ==== verilog/atacpe_engine.sv ====
// Summary of operation
// - Data-out: BSY on accept, DRQ per unit
// - One unit per DRQ, then BSY again
// - Per-unit interrupt, status read clears it
// - Long write: one sector plus ECC bytes
// - Words are 16 bits, ECC bytes 8 bits
// - 512-byte sector; multiple write moves blocks
// - Invalid parameter aborts with ERR, ABT, interrupt
// - Uncorrectable error: ERR, error code, address kept
// - Error address form follows latched LBA bit
// - Non-data: BSY, then completion interrupt
// - DMA request whenever ready for data
// - DMA interrupts once, after all data
// - Health opcode decodes its feature values
// - Set-features decodes cache, mode, power, look-ahead
// - Set-features offset mode and ECC length
// - Only the selected device responds
// - BSY or DRQ held until completion
// - Status read, reset, command write clear interrupt
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module atacpe_engine
  import atacpe_pkg::*;
#(
  parameter int PROC_CYCLES = 4,
  parameter logic DEV_NUMBER = 1'b0,
  parameter logic [31:0] DEV_ID = 32'h0000_5a5a // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Task-file interrupt and DMA
  output logic intrq,
  output logic dmaRq,
  input wire logic dmaAck,
  // Media side result strobes
  input wire logic mediaDone,
  input wire logic mediaUnc,
  // Captured data toward the media
  output logic [15:0] wrWord,
  output logic wrWordValid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_PREP, ST_XFER, ST_PROC, ST_DMA, ST_DMAEND
  } atacpe_state_t;

  atacpe_state_t state_reg;
  atacpe_class_t cls_reg;
  atacpe_feat_t feat_reg;
  logic [7:0] featReg_reg, secCnt_reg, secNum_reg, cylLo_reg, cylHi_reg;
  logic [7:0] devHead_reg, status_reg, error_reg, multCnt_reg;
  logic [7:0] unitsLeft_reg, sectInUnit_reg;
  logic [8:0] wordCnt_reg;
  logic [5:0] eccCnt_reg;
  logic [7:0] procCnt_reg;
  logic lbaMode_reg;

  wire logic apbAcc = psel && penable;
  wire logic apbWr = apbAcc && pwrite;
  wire logic apbRd = apbAcc && !pwrite;
  wire logic selected = (devHead_reg[DH_DEV] == DEV_NUMBER);
  wire logic busy = status_reg[STAT_BSY] || status_reg[STAT_DRQ];
  wire logic cmdWr = apbWr && (paddr == TF_COMMAND_OFF) && selected && !busy;
  wire logic softRst = apbWr && (paddr == CTL_RESET_OFF) && pwdata[2];
  wire logic anyRst = reset || softRst;
  wire logic statRd = apbRd && (paddr == TF_STATUS_OFF);
  wire logic wordWr = apbWr && (paddr == TF_DATA16_OFF) && status_reg[STAT_DRQ];
  wire logic byteWr = apbWr && (paddr == TF_DATA8_OFF) && status_reg[STAT_DRQ];
  wire logic [7:0] opc = pwdata[7:0];

  // ----------------------------------------------------------------
  // Opcode classification
  // ----------------------------------------------------------------
  atacpe_class_t cmdCls;
  logic cmdBad;
  always_comb begin
    cmdCls = CLS_NONE;
    cmdBad = 1'b0;
    case (opc)
      OP_WRITE_SECT, OP_WRITE_SECT_NR, OP_WRITE_VERIFY, OP_WRITE_BUF: cmdCls = CLS_PIO_OUT;
      OP_WRITE_MULT: begin
        cmdCls = CLS_PIO_OUT;
        cmdBad = (multCnt_reg == 8'h00);
      end
      OP_WRITE_LONG, OP_WRITE_LONG_NR: cmdCls = CLS_LONG;
      OP_READ_DMA, OP_READ_DMA_NR, OP_WRITE_DMA, OP_WRITE_DMA_NR: cmdCls = CLS_DMA;
      OP_FLUSH, OP_CHK_PWR, OP_IDLE_IMM, OP_RECAL, OP_SET_MULT: cmdCls = CLS_NODATA;
      OP_HEALTH: begin
        cmdCls = CLS_NODATA;
        case (featReg_reg)
          HM_AUTOSAVE, HM_SAVE, HM_OFFLINE, HM_ENABLE, HM_DISABLE, HM_STATUS: cmdBad = 1'b0;
          default: cmdBad = 1'b1;
        endcase
        // Attribute reads are data-in and not handled by this engine
        if (featReg_reg == HM_READ_VAL || featReg_reg == HM_READ_THR) begin
          cmdBad = 1'b1;
        end
      end
      OP_SET_FEAT: begin
        cmdCls = CLS_NODATA;
        case (featReg_reg)
          SF_WC_ON, SF_WC_OFF, SF_XFER_MODE, SF_PM_ON, SF_PM_OFF, SF_AO_ON, SF_AO_OFF,
          SF_ECC34, SF_ECC4, SF_RLA_ON, SF_RLA_OFF, SF_REV_ON, SF_REV_OFF: cmdBad = 1'b0;
          default: cmdBad = 1'b1;
        endcase
      end
      default: cmdBad = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Task-file parameter registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      featReg_reg <= 8'h00;
      secCnt_reg <= 8'h01;
      secNum_reg <= 8'h01;
      cylLo_reg <= 8'h00;
      cylHi_reg <= 8'h00;
      devHead_reg <= 8'ha0;
      multCnt_reg <= MULT_RST;
    end else if (apbWr && !busy) begin
      case (paddr)
        TF_FEATURES_OFF: featReg_reg <= pwdata[7:0];
        TF_SECCOUNT_OFF: secCnt_reg <= pwdata[7:0];
        TF_SECNUM_OFF: secNum_reg <= pwdata[7:0];
        TF_CYLLO_OFF: cylLo_reg <= pwdata[7:0];
        TF_CYLHI_OFF: cylHi_reg <= pwdata[7:0];
        TF_DEVHEAD_OFF: devHead_reg <= pwdata[7:0];
        TF_COMMAND_OFF: begin
          if (cmdWr && !cmdBad && opc == OP_SET_MULT) begin
            multCnt_reg <= secCnt_reg;
          end
        end
        default: ;
      endcase
    end else if (state_reg == ST_PROC && procCnt_reg == 8'h00 && mediaUnc) begin
      // Failing sector location stays in place, in the form latched at issue
      secNum_reg <= secNum_reg;
    end else if (state_reg == ST_PROC && procCnt_reg == 8'h00 && mediaDone) begin
      if (lbaMode_reg) begin
        {devHead_reg[3:0], cylHi_reg, cylLo_reg, secNum_reg} <=
          28'({devHead_reg[3:0], cylHi_reg, cylLo_reg, secNum_reg} + 28'd1);
      end else begin
        secNum_reg <= 8'(secNum_reg + 8'd1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Feature state from subcommands
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      feat_reg <= FEAT_RST;
    end else if (cmdWr && !cmdBad && opc == OP_SET_FEAT) begin
      case (featReg_reg)
        SF_WC_ON: feat_reg.writeCache <= 1'b1;
        SF_WC_OFF: feat_reg.writeCache <= 1'b0;
        SF_PM_ON: feat_reg.powerMgmt <= 1'b1;
        SF_PM_OFF: feat_reg.powerMgmt <= 1'b0;
        SF_AO_ON: feat_reg.addrOffset <= 1'b1;
        SF_AO_OFF: feat_reg.addrOffset <= 1'b0;
        SF_RLA_ON: feat_reg.readAhead <= 1'b1;
        SF_RLA_OFF: feat_reg.readAhead <= 1'b0;
        SF_REV_ON: feat_reg.revertDefaults <= 1'b1;
        SF_REV_OFF: feat_reg.revertDefaults <= 1'b0;
        SF_ECC34: feat_reg.ecc34 <= 1'b1;
        SF_ECC4: feat_reg.ecc34 <= 1'b0;
        default: ;
      endcase
    end else if (cmdWr && !cmdBad && opc == OP_HEALTH) begin
      case (featReg_reg)
        HM_ENABLE: feat_reg.healthOn <= 1'b1;
        HM_DISABLE: feat_reg.healthOn <= 1'b0;
        HM_AUTOSAVE: feat_reg.autosave <= secCnt_reg != 8'h00;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Protocol sequencer
  // ----------------------------------------------------------------
  wire logic unitEnd = (cls_reg == CLS_LONG) ?
    (wordCnt_reg == 9'(SECTOR_WORDS) && byteWr && eccCnt_reg == 6'd1) :
    (wordWr && wordCnt_reg == 9'(SECTOR_WORDS - 1) && sectInUnit_reg == 8'h01);
  wire logic procDone = (procCnt_reg == 8'h00) && (mediaDone || mediaUnc);

  always_ff @(posedge core_clk) begin
    if (anyRst) begin
      state_reg <= ST_IDLE;
      cls_reg <= CLS_NONE;
      status_reg <= STATUS_RST;
      error_reg <= 8'h00;
      intrq <= 1'b0;
      dmaRq <= 1'b0;
      lbaMode_reg <= 1'b0;
      unitsLeft_reg <= 8'h00;
      sectInUnit_reg <= 8'h00;
      wordCnt_reg <= 9'd0;
      eccCnt_reg <= 6'd0;
      procCnt_reg <= 8'h00;
    end else begin
      if (statRd) begin
        intrq <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (cmdWr) begin
            intrq <= 1'b0;
            lbaMode_reg <= devHead_reg[DH_LBA];
            cls_reg <= cmdCls;
            unitsLeft_reg <= secCnt_reg;
            procCnt_reg <= 8'(PROC_CYCLES);
            error_reg <= 8'h00;
            wordCnt_reg <= 9'd0;
            if (cmdBad) begin
              status_reg <= STATUS_RST | 8'h01;
              error_reg <= 8'h04;
              intrq <= 1'b1;
            end else begin
              status_reg <= 8'h80;
              state_reg <= (cmdCls == CLS_NODATA) ? ST_PROC :
                           (cmdCls == CLS_DMA) ? ST_DMA : ST_PREP;
            end
          end
        end
        ST_PREP: begin
          status_reg <= 8'h08 | (STATUS_RST & 8'h7f);
          wordCnt_reg <= 9'd0;
          eccCnt_reg <= feat_reg.ecc34 ? ECC_LEN_LONG : ECC_LEN_SHORT;
          sectInUnit_reg <= (cls_reg == CLS_PIO_OUT && multCnt_reg > 8'h01) ?
            ((unitsLeft_reg != 8'h00 && unitsLeft_reg < multCnt_reg) ? unitsLeft_reg
              : multCnt_reg) : 8'h01;
          state_reg <= ST_XFER;
        end
        ST_XFER: begin
          if (wordWr && wordCnt_reg != 9'(SECTOR_WORDS)) begin
            wordCnt_reg <= (wordCnt_reg == 9'(SECTOR_WORDS - 1) && cls_reg != CLS_LONG
              && sectInUnit_reg != 8'h01) ? 9'd0 : 9'(wordCnt_reg + 9'd1);
            if (wordCnt_reg == 9'(SECTOR_WORDS - 1) && cls_reg != CLS_LONG) begin
              sectInUnit_reg <= 8'(sectInUnit_reg - 8'h01);
              unitsLeft_reg <= 8'(unitsLeft_reg - 8'h01);
            end
          end
          if (byteWr && cls_reg == CLS_LONG && wordCnt_reg == 9'(SECTOR_WORDS)) begin
            eccCnt_reg <= 6'(eccCnt_reg - 6'd1);
          end
          if (unitEnd) begin
            status_reg <= 8'h80;
            procCnt_reg <= 8'(PROC_CYCLES);
            state_reg <= ST_PROC;
            if (cls_reg == CLS_LONG) begin
              unitsLeft_reg <= 8'h01;
            end
          end
        end
        ST_PROC: begin
          if (procCnt_reg != 8'h00) begin
            procCnt_reg <= 8'(procCnt_reg - 8'h01);
          end else if (procDone) begin
            intrq <= 1'b1;
            if (mediaUnc) begin
              status_reg <= STATUS_RST | 8'h01;
              error_reg <= 8'h40;
              state_reg <= ST_IDLE;
            end else if (cls_reg == CLS_PIO_OUT && unitsLeft_reg != 8'h00) begin
              status_reg <= 8'h08 | (STATUS_RST & 8'h7f);
              state_reg <= ST_PREP;
            end else begin
              status_reg <= STATUS_RST;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_DMA: begin
          dmaRq <= 1'b1;
          if (dmaAck && dmaRq) begin
            wordCnt_reg <= (wordCnt_reg == 9'(SECTOR_WORDS - 1)) ? 9'd0
              : 9'(wordCnt_reg + 9'd1);
            if (wordCnt_reg == 9'(SECTOR_WORDS - 1)) begin
              unitsLeft_reg <= 8'(unitsLeft_reg - 8'h01);
              if (unitsLeft_reg == 8'h01) begin
                dmaRq <= 1'b0;
                state_reg <= ST_DMAEND;
              end
            end
          end
        end
        ST_DMAEND: begin
          status_reg <= STATUS_RST;
          intrq <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data capture toward the media
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrWord <= 16'h0000;
      wrWordValid <= 1'b0;
    end else begin
      wrWordValid <= (wordWr && state_reg == ST_XFER) || (byteWr && cls_reg == CLS_LONG);
      wrWord <= byteWr ? {8'h00, pwdata[7:0]} : pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        pslverr <= paddr > DEV_ID_OFF || paddr[1:0] != 2'b00;
        case (paddr)
          TF_FEATURES_OFF: prdata <= {24'h0, featReg_reg};
          TF_SECCOUNT_OFF: prdata <= {24'h0, secCnt_reg};
          TF_SECNUM_OFF: prdata <= {24'h0, secNum_reg};
          TF_CYLLO_OFF: prdata <= {24'h0, cylLo_reg};
          TF_CYLHI_OFF: prdata <= {24'h0, cylHi_reg};
          TF_DEVHEAD_OFF: prdata <= {24'h0, devHead_reg};
          TF_STATUS_OFF: prdata <= {24'h0, selected ? status_reg : 8'h00};
          TF_ERROR_OFF: prdata <= {24'h0, error_reg};
          MEDIA_CTL_OFF: prdata <= {16'h0, multCnt_reg, 5'h0, cls_reg};
          CFG_STATE_OFF: prdata <= {24'h0, feat_reg};
          DEV_ID_OFF: prdata <= DEV_ID;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // atacpe_engine

// ==== common/atacpe_pkg.sv ====
package atacpe_pkg;

  // ----------------------------------------------------------------
  // APB register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TF_FEATURES_OFF = 8'h00;
  localparam logic [7:0] TF_SECCOUNT_OFF = 8'h04;
  localparam logic [7:0] TF_SECNUM_OFF = 8'h08;
  localparam logic [7:0] TF_CYLLO_OFF = 8'h0c;
  localparam logic [7:0] TF_CYLHI_OFF = 8'h10;
  localparam logic [7:0] TF_DEVHEAD_OFF = 8'h14;
  localparam logic [7:0] TF_COMMAND_OFF = 8'h18;
  localparam logic [7:0] TF_STATUS_OFF = 8'h1c;
  localparam logic [7:0] TF_ERROR_OFF = 8'h20;
  localparam logic [7:0] TF_DATA16_OFF = 8'h24;
  localparam logic [7:0] TF_DATA8_OFF = 8'h28;
  localparam logic [7:0] CTL_RESET_OFF = 8'h2c;
  localparam logic [7:0] MEDIA_CTL_OFF = 8'h30;
  localparam logic [7:0] CFG_STATE_OFF = 8'h34;
  localparam logic [7:0] DEV_ID_OFF = 8'h38;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_BSY = 7;
  localparam int STAT_RDY = 6;
  localparam int STAT_DSC = 4;
  localparam int STAT_DRQ = 3;
  localparam int STAT_ERR = 0;
  localparam int ERRB_UNC = 6;
  localparam int ERRB_ABT = 2;
  localparam int DH_LBA = 6;
  localparam int DH_DEV = 4;

  // ----------------------------------------------------------------
  // Opcodes and subcommands
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_SECT = 8'h30;
  localparam logic [7:0] OP_WRITE_SECT_NR = 8'h31;
  localparam logic [7:0] OP_WRITE_LONG = 8'h32;
  localparam logic [7:0] OP_WRITE_LONG_NR = 8'h33;
  localparam logic [7:0] OP_WRITE_VERIFY = 8'h3c;
  localparam logic [7:0] OP_WRITE_MULT = 8'hc5;
  localparam logic [7:0] OP_WRITE_BUF = 8'he8;
  localparam logic [7:0] OP_READ_DMA = 8'hc8;
  localparam logic [7:0] OP_READ_DMA_NR = 8'hc9;
  localparam logic [7:0] OP_WRITE_DMA = 8'hca;
  localparam logic [7:0] OP_WRITE_DMA_NR = 8'hcb;
  localparam logic [7:0] OP_HEALTH = 8'hb0;
  localparam logic [7:0] OP_SET_FEAT = 8'hef;
  localparam logic [7:0] OP_FLUSH = 8'he7;
  localparam logic [7:0] OP_CHK_PWR = 8'he5;
  localparam logic [7:0] OP_IDLE_IMM = 8'he1;
  localparam logic [7:0] OP_RECAL = 8'h10;
  localparam logic [7:0] OP_SET_MULT = 8'hc6;

  localparam logic [7:0] HM_READ_VAL = 8'hd0;
  localparam logic [7:0] HM_READ_THR = 8'hd1;
  localparam logic [7:0] HM_AUTOSAVE = 8'hd2;
  localparam logic [7:0] HM_SAVE = 8'hd3;
  localparam logic [7:0] HM_OFFLINE = 8'hd4;
  localparam logic [7:0] HM_ENABLE = 8'hd8;
  localparam logic [7:0] HM_DISABLE = 8'hd9;
  localparam logic [7:0] HM_STATUS = 8'hda;

  localparam logic [7:0] SF_WC_ON = 8'h02;
  localparam logic [7:0] SF_WC_OFF = 8'h82;
  localparam logic [7:0] SF_XFER_MODE = 8'h03;
  localparam logic [7:0] SF_PM_ON = 8'h05;
  localparam logic [7:0] SF_PM_OFF = 8'h85;
  localparam logic [7:0] SF_AO_ON = 8'h09;
  localparam logic [7:0] SF_AO_OFF = 8'h89;
  localparam logic [7:0] SF_ECC34 = 8'h44;
  localparam logic [7:0] SF_ECC4 = 8'hbb;
  localparam logic [7:0] SF_RLA_ON = 8'haa;
  localparam logic [7:0] SF_RLA_OFF = 8'h55;
  localparam logic [7:0] SF_REV_ON = 8'hcc;
  localparam logic [7:0] SF_REV_OFF = 8'h66;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int SECTOR_WORDS = 256;
  localparam logic [5:0] ECC_LEN_LONG = 6'd34;
  localparam logic [5:0] ECC_LEN_SHORT = 6'd4;
  localparam logic [7:0] STATUS_RST = 8'h50;
  localparam logic [7:0] MULT_RST = 8'h01;

  typedef enum logic [2:0] {
    CLS_NONE, CLS_PIO_OUT, CLS_LONG, CLS_NODATA, CLS_DMA
  } atacpe_class_t;

  // Feature state set by subcommands
  typedef struct packed {
    logic writeCache;
    logic powerMgmt;
    logic addrOffset;
    logic readAhead;
    logic revertDefaults;
    logic healthOn;
    logic autosave;
    logic ecc34;
  } atacpe_feat_t;

  localparam atacpe_feat_t FEAT_RST = 8'b1001_1101;

endpackage

// ==== verif/atacpe_checker.sv ====
`timescale 1ns/1ps
module atacpe_checker
  import atacpe_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt, DMA and media
  input wire logic intrq,
  input wire logic dmaRq,
  input wire logic dmaAck,
  input wire logic mediaDone,
  input wire logic mediaUnc,
  input wire logic [15:0] wrWord,
  input wire logic wrWordValid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic setup;
  logic clrHit;
  logic statRd;
  logic softRst_reg;
  logic dataWr_reg;
  logic [15:0] pwd_reg;
  assign setup = psel && !penable;
  assign clrHit = psel && (paddr == TF_STATUS_OFF || paddr == TF_COMMAND_OFF
    || paddr == CTL_RESET_OFF);
  assign statRd = pready && !pwrite && paddr == TF_STATUS_OFF;

  always_ff @(posedge core_clk) begin
    softRst_reg <= psel && pwrite && paddr == CTL_RESET_OFF;
  end
  always_ff @(posedge core_clk) begin
    dataWr_reg <= psel && penable && pwrite && paddr == TF_DATA16_OFF;
    pwd_reg <= pwdata[15:0];
  end

  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("access phase not answered at once");
  a_slverr_range: assert property (setup && paddr > 8'h38 |=> pready && pslverr)
    else $error("unmapped access not refused");
  a_irq_holds: assert property (intrq && !clrHit |=> intrq)
    else $error("interrupt dropped without a clearing access");
  a_status_clears: assert property (statRd && !mediaDone && !mediaUnc |=> !intrq)
    else $error("status read left interrupt pending");
  a_dma_no_irq: assert property (dmaRq |-> !intrq)
    else $error("interrupt during DMA transfer");
  a_dma_done_irq: assert property ($fell(dmaRq) && !softRst_reg |-> ##[0:1] intrq)
    else $error("no interrupt after DMA transfer");
  a_busy_in_dma: assert property (statRd && $past(dmaRq) |-> prdata[STAT_BSY] || prdata[STAT_DRQ])
    else $error("neither busy nor request during command");
  a_idle_on_irq: assert property (statRd && $past(intrq) |-> !prdata[STAT_BSY])
    else $error("busy still set with interrupt pending");
  a_word_capture: assert property (wrWordValid && dataWr_reg |-> wrWord == pwd_reg)
    else $error("captured word differs from data written");

  c_dma_end: cover property ($fell(dmaRq));
  c_refused: cover property (setup && paddr > 8'h38);
  c_word: cover property (wrWordValid && dataWr_reg);
endmodule // atacpe_checker

bind atacpe_engine atacpe_checker atacpe_checker_i (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .intrq(intrq), .dmaRq(dmaRq), .dmaAck(dmaAck), .mediaDone(mediaDone),
  .mediaUnc(mediaUnc), .wrWord(wrWord), .wrWordValid(wrWordValid)
);

// ==== verif/atacpe_dma_host.sv ====
`timescale 1ns/1ps
module atacpe_dma_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // DMA handshake
  input wire logic dmaRq,
  input wire logic slow,
  output logic dmaAck,
  output int moved
);
  // Channel is armed before the opcode; slow mode stalls every other cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dmaAck <= 1'b0;
      moved <= 0;
    end else begin
      if (dmaAck && dmaRq) begin
        moved <= moved + 1;
      end
      dmaAck <= dmaRq && (!slow || !dmaAck);
    end
  end
endmodule // atacpe_dma_host

// ==== verif/ata_command_protocol_engine_bench.sv ====
`timescale 1ns/1ps
module ata_command_protocol_engine_bench;
  import atacpe_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mediaDone = 1'b0;
  logic mediaUnc = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] wrWord;
  logic pready, pslverr, intrq, dmaRq, dmaAck, wrWordValid, err;
  int moved;
  int words = 0;
  int failures = 0;
  int total_checks = 0;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (wrWordValid === 1'b1) words <= words + 1;

  atacpe_engine #(.PROC_CYCLES(1)) atacpe_engine_i (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intrq(intrq), .dmaRq(dmaRq), .dmaAck(dmaAck), .mediaDone(mediaDone),
    .mediaUnc(mediaUnc), .wrWord(wrWord), .wrWordValid(wrWordValid));
  atacpe_dma_host atacpe_dma_host_i (.core_clk(core_clk), .reset(reset), .dmaRq(dmaRq),
    .slow(slow), .dmaAck(dmaAck), .moved(moved));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setup_cmd(input logic [7:0] f, input logic [7:0] cnt, input logic [7:0] dh,
                           input logic [7:0] op);
    int n;
    n = 0;
    do begin
      apb(1'b0, TF_STATUS_OFF, 32'h0);
      n++;
    end while (rd[STAT_BSY:STAT_RDY] !== 2'b01 && n < 50);
    apb(1'b1, TF_FEATURES_OFF, f);
    apb(1'b1, TF_SECCOUNT_OFF, cnt);
    apb(1'b1, TF_SECNUM_OFF, 8'h07);
    apb(1'b1, TF_DEVHEAD_OFF, dh);
    apb(1'b1, TF_COMMAND_OFF, op);
  endtask

  task automatic finish(input logic [31:0] stat, input logic [31:0] errv);
    int n;
    n = 0;
    mediaDone <= 1'b1;
    while (intrq !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    check("intrq raised", intrq, 1'b1);
    mediaDone <= 1'b0;
    apb(1'b0, TF_STATUS_OFF, 32'h0);
    check("status", rd, stat);
    apb(1'b0, TF_ERROR_OFF, 32'h0);
    check("error", rd, errv);
    check("intrq cleared", intrq, 1'b0);
  endtask

  task automatic wait_drq();
    int n;
    n = 0;
    do begin
      apb(1'b0, TF_STATUS_OFF, 32'h0);
      n++;
    end while (rd[STAT_DRQ] !== 1'b1 && n < 50);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, TF_STATUS_OFF, 32'h0);
    check("reset status", rd, STATUS_RST);
    apb(1'b0, 8'h3c, 32'h0);
    check("unmapped refused", err, 1'b1);
  endtask

  task automatic t_pio(input logic [7:0] op, input logic [7:0] cnt, input int ecc,
                       input logic unc);
    int w0;
    w0 = words;
    mediaUnc <= unc;
    setup_cmd(8'h00, cnt, 8'he0, op);
    for (int u = 0; u < cnt; u++) begin
      wait_drq();
      check("ready status", rd, 32'h58);
      for (int i = 0; i < SECTOR_WORDS; i++) apb(1'b1, TF_DATA16_OFF, 32'ha500 + i);
      for (int i = 0; i < ecc; i++) apb(1'b1, TF_DATA8_OFF, 32'h30 + i);
      finish(unc ? 32'h51 : (u == cnt - 1) ? 32'h50 : 32'h58,
             unc ? 32'h40 : 32'h0);
    end
    mediaUnc <= 1'b0;
    check("unit words", words - w0, cnt * (SECTOR_WORDS + ecc));
    apb(1'b0, TF_SECNUM_OFF, 32'h0);
    check("sector address", rd, unc ? 32'h07 : 32'h07 + cnt);
  endtask

  task automatic t_codes(input logic [15:0] tbl[], input logic [31:0] st, input logic [31:0] ev);
    foreach (tbl[i]) begin
      setup_cmd(tbl[i][7:0], 8'h01, 8'ha0, tbl[i][15:8]);
      finish(st, ev);
    end
  endtask

  task automatic t_dma(input logic [7:0] op, input logic [7:0] cnt, input logic s);
    int m0;
    m0 = moved;
    slow <= s;
    setup_cmd(8'h00, cnt, 8'he0, op);
    apb(1'b0, TF_STATUS_OFF, 32'h0);
    check("dma busy", rd[STAT_BSY], 1'b1);
    check("dma request", dmaRq, 1'b1);
    finish(32'h50, 32'h0);
    check("dma words", moved - m0, cnt * SECTOR_WORDS);
  endtask

  task automatic t_other_dev();
    setup_cmd(8'h00, 8'h01, 8'hb0, OP_FLUSH);
    repeat (20) @(posedge core_clk);
    check("other device intrq", intrq, 1'b0);
    apb(1'b0, TF_STATUS_OFF, 32'h0);
    check("other device status", rd, 32'h00);
    apb(1'b1, TF_DEVHEAD_OFF, 32'ha0);
    apb(1'b0, TF_STATUS_OFF, 32'h0);
    check("own device status", rd, 32'h50);
  endtask

  task automatic t_abandon();
    setup_cmd(8'h00, 8'h01, 8'he0, OP_WRITE_SECT);
    wait_drq();
    apb(1'b1, CTL_RESET_OFF, 32'h4);
    apb(1'b1, CTL_RESET_OFF, 32'h0);
    apb(1'b0, TF_STATUS_OFF, 32'h0);
    check("abandon status", rd, 32'h50);
    check("abandon intrq", intrq, 1'b0);
  endtask

  initial begin
    #300000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_pio(OP_WRITE_SECT, 8'h02, 0, 1'b0);
    t_pio(OP_WRITE_MULT, 8'h01, 0, 1'b0);
    t_pio(OP_WRITE_LONG, 8'h01, 34, 1'b0);
    t_codes('{{OP_HEALTH, HM_DISABLE}, {OP_HEALTH, HM_ENABLE}, {OP_HEALTH, HM_AUTOSAVE},
      {OP_HEALTH, HM_SAVE}, {OP_HEALTH, HM_OFFLINE}, {OP_HEALTH, HM_STATUS},
      {OP_SET_FEAT, SF_WC_ON}, {OP_SET_FEAT, SF_WC_OFF}, {OP_SET_FEAT, SF_XFER_MODE},
      {OP_SET_FEAT, SF_PM_ON}, {OP_SET_FEAT, SF_PM_OFF}, {OP_SET_FEAT, SF_AO_ON},
      {OP_SET_FEAT, SF_AO_OFF}, {OP_SET_FEAT, SF_ECC34}, {OP_SET_FEAT, SF_ECC4},
      {OP_SET_FEAT, SF_RLA_ON}, {OP_SET_FEAT, SF_RLA_OFF}, {OP_SET_FEAT, SF_REV_ON},
      {OP_SET_FEAT, SF_REV_OFF}}, 32'h50, 32'h0);
    t_pio(OP_WRITE_LONG, 8'h01, 4, 1'b0);
    t_pio(OP_WRITE_VERIFY, 8'h01, 0, 1'b1);
    t_codes('{16'h0000, {OP_SET_FEAT, 8'h77}, {OP_HEALTH, HM_READ_VAL}}, 32'h51, 32'h04);
    t_dma(OP_READ_DMA, 8'h02, 1'b1);
    t_dma(OP_WRITE_DMA, 8'h01, 1'b0);
    t_other_dev();
    t_abandon();
    end_of_test();
  end
endmodule // ata_command_protocol_engine_bench
